//--- core/occ_control.sv
// OSD setup-command interpreter: serial byte receiver, command decode and the setup state.
// Assumes the host drives the serial pins, and the slicer and video logic on sys_clk feed
// line timing, byte verdict requests and the other line-background selections.
`timescale 1ns/1ps
`default_nettype none
`include "occ_regs.svh"
// How it works
// - A command is a code byte, then a data byte whose top bit is 0.
// - The reset pin clears every command field to zero.
// - Third line-background command holds a 4-bit row and a 3-bit colour.
// - Row zero means no change; rows 1 to 12 are binary 1 to 12.
// - Colour codes 0 to 7 are cyan, yellow, red, blue, cyan-blue, green, orange, magenta.
// - Same row chosen twice: the latest wins and the older fields clear to zero.
// - A set stop bit halts the LC oscillator or the VCO; zero keeps it running.
// - Third-row reverse characters take global background; variant picks white background or glyph.
// - Same substitution for second rows; variant ignored while select is zero.
// - External sync dot clock: 00 LC, 01 crystal, 10 VCO.
// - Judge pin shows presence, halftone, lock or detect; halftone ORs all three rows.
// - External sync H timing: separated sync when 0, slicer AFC signal when 1.
// - Internal sync dot clock: LC when 0, crystal when 1.
// - Noise count 0 disables, else needs 4 to 256 lines; a bit picks alternate threshold.
// - Sync is absent once the threshold of high samples is seen within one line.
// - Two bits pick the sync sampling period, with separate PAL and NTSC values.
// - Acquisition phase shifts the slicer sampling clock in steps of eight units.
// - Four bits select the slicer operating mode.
// - V-mask start and length each chosen by their own bit.
// - Clock run needs 2 or 4 occurrences; framing may tolerate one bad bit.
// - Bypass off passes only error-free checked bytes; on passes every byte.
// - Unchecked failing bytes are held or written; VPS write also needs error bit 0.
// - One bit disables checking on the unused bytes of the VPS and PDC modes.
// - VPS bytes 12 to 15 each have a check-off bit that makes them unchecked.
module occ_control
  import occ_pkg::*;
#(
  parameter int ABSENT_THR     = 8,
  parameter int ABSENT_THR_ALT = 4
) (
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  input  wire logic       link_sclk,
  input  wire logic       link_cs_b,
  input  wire logic       link_sin,
  input  wire logic       ext_sync_mode,
  input  wire logic       pal_mode,
  input  wire logic       hsync_extract_in,
  input  wire logic       h_line_start,
  input  wire logic [3:0] disp_row,
  input  wire logic       lock_in,
  input  wire logic       sync_det_in,
  input  wire logic [3:0] line_a_row,
  input  wire logic       line_a_wr,
  input  wire logic [3:0] line_b_row,
  input  wire logic       line_b_wr,
  input  wire occ_byte_t  byte_req,
  output logic [3:0]      third_line_sel,
  output logic [2:0]      third_line_color,
  output logic            line_a_clr,
  output logic            line_b_clr,
  output logic            lc_osc_stop,
  output logic            vco_stop,
  output logic [1:0]      third_rows_mode,
  output logic [1:0]      second_rows_mode,
  output occ_dot_src_t    dot_clk_src,
  output logic            h_input_source,
  output logic            sync_judge_pin,
  output logic            sync_present,
  output logic [7:0]      sample_period,
  output logic [5:0]      acq_shift,
  output occ_mode_t       slicer_mode,
  output logic            vmask_start_sel,
  output logic            vmask_length_sel,
  output logic [2:0]      clock_run_count,
  output logic            framing_tolerance_sel,
  output logic            byte_write_valid,
  output logic            byte_write_ok
);

  // Reset release through two flops; assertion stays asynchronous.
  logic rst_m_q, rst_s_q;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_m_q <= 1'b0;
      rst_s_q <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_s_q <= rst_m_q;
    end
  end

  // Link domain: bytes arrive MSB first while the select is low.
  logic [2:0] bit_cnt_q;
  logic [6:0] shift_q;
  logic [7:0] lbyte_q;
  logic       ltog_q;
  always_ff @(posedge link_sclk or posedge link_cs_b) begin
    if (link_cs_b) begin
      bit_cnt_q <= 3'h0;
    end else begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
    end
  end

  always_ff @(posedge link_sclk) begin
    shift_q <= {shift_q[5:0], link_sin};
  end

  // The byte word stays stable for eight link clocks after the toggle, long enough
  // for the system side to take it after the toggle has been synchronised.
  always_ff @(posedge link_sclk or negedge rst_b) begin
    if (!rst_b) begin
      lbyte_q <= 8'h00;
      ltog_q  <= 1'b0;
    end else if (!link_cs_b && bit_cnt_q == 3'h7) begin
      lbyte_q <= {shift_q, link_sin};
      ltog_q  <= ~ltog_q;
    end
  end

  // Crossings into sys_clk.
  logic tog_m_q, tog_s_q, tog_d_q;
  logic cs_m_q, cs_s_q;
  logic hs_m_q, hs_s_q;
  always_ff @(posedge sys_clk or negedge rst_s_q) begin
    if (!rst_s_q) begin
      tog_m_q <= 1'b0;
      tog_s_q <= 1'b0;
      tog_d_q <= 1'b0;
      cs_m_q  <= 1'b1;
      cs_s_q  <= 1'b1;
      hs_m_q  <= 1'b0;
      hs_s_q  <= 1'b0;
    end else begin
      tog_m_q <= ltog_q;
      tog_s_q <= tog_m_q;
      tog_d_q <= tog_s_q;
      cs_m_q  <= link_cs_b;
      cs_s_q  <= cs_m_q;
      hs_m_q  <= hsync_extract_in;
      hs_s_q  <= hs_m_q;
    end
  end

  logic       byte_ev;
  logic [7:0] rx_byte;
  assign byte_ev = tog_s_q ^ tog_d_q;
  assign rx_byte = lbyte_q;

  // Pairing of code and data bytes.
  occ_state_t st_q;
  logic [7:0] code_q;
  logic       cmd_wr;
  assign cmd_wr = byte_ev && st_q == OCC_ST_DATA && !rx_byte[`OCC_DATA_FLAG_BIT];

  always_ff @(posedge sys_clk or negedge rst_s_q) begin
    if (!rst_s_q) begin
      st_q   <= OCC_ST_CODE;
      code_q <= `OCC_RESET_VAL;
    end else begin
      case (st_q)
        OCC_ST_CODE: begin
          if (byte_ev && rx_byte[`OCC_DATA_FLAG_BIT]) begin
            st_q   <= OCC_ST_DATA;
            code_q <= rx_byte;
          end
        end
        OCC_ST_DATA: begin
          // A second code byte restarts the command; a frame end drops it unfinished.
          if (byte_ev && rx_byte[`OCC_DATA_FLAG_BIT]) begin
            code_q <= rx_byte;
          end else if (byte_ev || cs_s_q) begin
            st_q <= OCC_ST_CODE;
          end
        end
        default: begin
          st_q <= OCC_ST_CODE;
        end
      endcase
    end
  end

  // Command fields.
  logic [7:0] osc_q, clk_q, sync_q, slc_q, pol_q, vps_q;
  logic       wr_c;
  assign wr_c = cmd_wr && code_q == `OCC_CODE_LINE_C;

  always_ff @(posedge sys_clk or negedge rst_s_q) begin
    if (!rst_s_q) begin
      osc_q  <= `OCC_RESET_VAL;
      clk_q  <= `OCC_RESET_VAL;
      sync_q <= `OCC_RESET_VAL;
      slc_q  <= `OCC_RESET_VAL;
      pol_q  <= `OCC_RESET_VAL;
      vps_q  <= `OCC_RESET_VAL;
    end else if (cmd_wr) begin
      case (code_q)
        `OCC_CODE_OSC:    osc_q  <= rx_byte;
        `OCC_CODE_CLK:    clk_q  <= rx_byte;
        `OCC_CODE_SYNC:   sync_q <= rx_byte;
        `OCC_CODE_SLICER: slc_q  <= rx_byte;
        `OCC_CODE_ERRPOL: pol_q  <= rx_byte;
        `OCC_CODE_VPSCHK: vps_q  <= rx_byte;
        default: begin
        end
      endcase
    end
  end

  // Third line background; a later write of the same row elsewhere clears the older one.
  logic [3:0] new_row;
  assign new_row = rx_byte[`OCC_LINE_SEL_LSB +: 4];

  always_ff @(posedge sys_clk or negedge rst_s_q) begin
    if (!rst_s_q) begin
      third_line_sel   <= 4'h0;
      third_line_color <= 3'h0;
      line_a_clr       <= 1'b0;
      line_b_clr       <= 1'b0;
    end else begin
      line_a_clr <= wr_c && new_row != 4'h0 && new_row == line_a_row;
      line_b_clr <= wr_c && new_row != 4'h0 && new_row == line_b_row;
      if (wr_c) begin
        third_line_sel   <= new_row;
        third_line_color <= rx_byte[`OCC_LINE_COL_LSB +: 3];
      end else if (third_line_sel != 4'h0 &&
                   ((line_a_wr && line_a_row == third_line_sel) ||
                    (line_b_wr && line_b_row == third_line_sel))) begin
        third_line_sel   <= 4'h0;
        third_line_color <= 3'h0;
      end
    end
  end

  // Oscillator, reverse-video and clock selections.
  always_ff @(posedge sys_clk or negedge rst_s_q) begin
    if (!rst_s_q) begin
      lc_osc_stop      <= 1'b0;
      vco_stop         <= 1'b0;
      third_rows_mode  <= 2'h0;
      second_rows_mode <= 2'h0;
      dot_clk_src      <= OCC_DOT_LC;
      h_input_source   <= 1'b0;
    end else begin
      lc_osc_stop <= osc_q[`OCC_LC_STOP_BIT];
      vco_stop    <= osc_q[`OCC_VCO_STOP_BIT];
      // Mode 0 normal, 1 background white, 2 glyph white.
      third_rows_mode <= !osc_q[`OCC_C_SEL_BIT] ? 2'h0 :
                         (osc_q[`OCC_C_VAR_BIT] ? 2'h2 : 2'h1);
      second_rows_mode <= !osc_q[`OCC_B_SEL_BIT] ? 2'h0 :
                          (osc_q[`OCC_B_VAR_BIT] ? 2'h2 : 2'h1);
      if (ext_sync_mode) begin
        // The undefined code 11 falls back to the LC oscillator.
        dot_clk_src <= (&clk_q[`OCC_EXT_DOT_LSB +: 2]) ? OCC_DOT_LC :
                       occ_dot_src_t'(clk_q[`OCC_EXT_DOT_LSB +: 2]);
      end else begin
        dot_clk_src <= clk_q[`OCC_INT_DOT_BIT] ? OCC_DOT_XTAL : OCC_DOT_LC;
      end
      h_input_source <= ext_sync_mode && clk_q[`OCC_H_IN_BIT];
    end
  end

  // Sync sampling period in system clocks.
  logic [7:0] per_d;
  always_comb begin
    case ({pal_mode, sync_q[`OCC_SCLK_SEL_LSB +: 2]})
      3'h4:    per_d = 8'(`OCC_PAL_S0_NS / `OCC_CLK_NS);
      3'h5:    per_d = 8'(`OCC_PAL_S1_NS / `OCC_CLK_NS);
      3'h6:    per_d = 8'(`OCC_PAL_S2_NS / `OCC_CLK_NS);
      3'h0:    per_d = 8'(`OCC_NTSC_S0_NS / `OCC_CLK_NS);
      3'h1:    per_d = 8'(`OCC_NTSC_S1_NS / `OCC_CLK_NS);
      3'h2:    per_d = 8'(`OCC_NTSC_S2_NS / `OCC_CLK_NS);
      // The undefined code 11 keeps the first period of the selected standard.
      3'h7:    per_d = 8'(`OCC_PAL_S0_NS / `OCC_CLK_NS);
      default: per_d = 8'(`OCC_NTSC_S0_NS / `OCC_CLK_NS);
    endcase
  end

  // Sync discrimination: high samples per line, then noise rejection on recovery.
  logic [7:0] div_q, hi_cnt_q;
  logic [8:0] ok_lines_q, need;
  logic [7:0] thr;
  logic [2:0] ncode;
  assign ncode = sync_q[`OCC_NOISE_LSB +: 3];
  assign need  = (ncode == 3'h0) ? 9'h000 : 9'(`OCC_NOISE_BASE << (ncode - 3'h1));
  assign thr   = sync_q[`OCC_THR_ALT_BIT] ? 8'(ABSENT_THR_ALT) : 8'(ABSENT_THR);

  always_ff @(posedge sys_clk or negedge rst_s_q) begin
    if (!rst_s_q) begin
      div_q         <= 8'h00;
      hi_cnt_q      <= 8'h00;
      ok_lines_q    <= 9'h000;
      sync_present  <= 1'b0;
      sample_period <= 8'h00;
    end else begin
      sample_period <= per_d;
      div_q <= (div_q + 8'h01 >= per_d) ? 8'h00 : div_q + 8'h01;
      if (h_line_start) begin
        hi_cnt_q <= 8'h00;
        if (hi_cnt_q >= thr) begin
          sync_present <= 1'b0;
          ok_lines_q   <= 9'h000;
        end else if (!sync_present) begin
          if (ok_lines_q + 9'h001 >= need) begin
            sync_present <= 1'b1;
            ok_lines_q   <= 9'h000;
          end else begin
            ok_lines_q <= ok_lines_q + 9'h001;
          end
        end
      end else if (div_q == 8'h00 && hs_s_q && hi_cnt_q != 8'hFF) begin
        hi_cnt_q <= hi_cnt_q + 8'h01;
      end
    end
  end

  // Judge pin source.
  logic halftone;
  assign halftone = disp_row != 4'h0 &&
                    (disp_row == line_a_row || disp_row == line_b_row ||
                     disp_row == third_line_sel);

  always_ff @(posedge sys_clk or negedge rst_s_q) begin
    if (!rst_s_q) begin
      sync_judge_pin <= 1'b0;
    end else begin
      case ({clk_q[`OCC_JUDGE_HI_BIT], clk_q[`OCC_JUDGE_LO_BIT]})
        2'h0:    sync_judge_pin <= sync_present;
        2'h1:    sync_judge_pin <= halftone;
        2'h2:    sync_judge_pin <= lock_in;
        default: sync_judge_pin <= sync_det_in;
      endcase
    end
  end

  // Slicer setup outputs.
  always_ff @(posedge sys_clk or negedge rst_s_q) begin
    if (!rst_s_q) begin
      acq_shift             <= 6'h00;
      slicer_mode           <= OCC_VPS;
      vmask_start_sel       <= 1'b0;
      vmask_length_sel      <= 1'b0;
      clock_run_count       <= 3'(`OCC_RUN_LOW);
      framing_tolerance_sel <= 1'b0;
    end else begin
      acq_shift        <= 6'(slc_q[`OCC_ACQ_LSB +: 3] * `OCC_ACQ_STEP);
      slicer_mode      <= occ_mode_t'(slc_q[`OCC_MODE_LSB +: 4]);
      vmask_start_sel  <= pol_q[`OCC_VM_START_BIT];
      vmask_length_sel <= pol_q[`OCC_VM_LEN_BIT];
      clock_run_count  <= pol_q[`OCC_RUN_BIT] ? 3'(`OCC_RUN_HIGH) : 3'(`OCC_RUN_LOW);
      framing_tolerance_sel <= pol_q[`OCC_FRAME_BIT];
    end
  end

  // Per-byte write verdict for the parallel-to-serial buffer.
  logic is_vps, unused, chk_off, ok_d;
  logic [5:0] n;
  always_comb begin
    n       = byte_req.num;
    is_vps  = slicer_mode == OCC_VPS;
    unused  = 1'b0;
    chk_off = 1'b0;
    if (is_vps) begin
      unused = n == 6'd3 || n == 6'd4 || (n >= 6'd6 && n <= 6'd10);
    end else if (slicer_mode == OCC_PDC) begin
      unused = n >= 6'd7 && n <= 6'd12;
    end
    if (unused) begin
      chk_off = pol_q[`OCC_UNUSED_OFF_BIT];
    end else if (is_vps && n >= 6'd12 && n <= 6'd15) begin
      chk_off = vps_q[`OCC_VPS12_BIT + 6'(n - 6'd12)];
    end
    if (pol_q[`OCC_BYPASS_BIT]) begin
      ok_d = 1'b1;
    end else if (!chk_off) begin
      ok_d = !byte_req.err;
    end else if (byte_req.err) begin
      ok_d = pol_q[`OCC_UNCHK_WR_BIT] && !(is_vps && byte_req.vps_err_bit);
    end else begin
      ok_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_s_q) begin
    if (!rst_s_q) begin
      byte_write_valid <= 1'b0;
      byte_write_ok    <= 1'b0;
    end else begin
      byte_write_valid <= byte_req.valid;
      byte_write_ok    <= byte_req.valid && ok_d;
    end
  end

endmodule : occ_control
`default_nettype wire

//--- core/occ_pkg.sv
// Types shared by the OSD setup-command block.
// Assumes the constants of occ_regs.svh.
`default_nettype none
package occ_pkg;
  typedef enum logic [1:0] {
    OCC_ST_CODE = 2'b01,
    OCC_ST_DATA = 2'b10
  } occ_state_t;
  typedef enum logic [1:0] {
    OCC_DOT_LC   = 2'b00,
    OCC_DOT_XTAL = 2'b01,
    OCC_DOT_VCO  = 2'b10
  } occ_dot_src_t;
  typedef enum logic [3:0] {
    OCC_VPS = 4'h0, OCC_PDC = 4'h1, OCC_AUTO1 = 4'h2, OCC_UDT = 4'h3,
    OCC_HDR1 = 4'h4, OCC_HDR2 = 4'h5, OCC_HDR3 = 4'h6, OCC_HDR4 = 4'h7,
    OCC_STS1 = 4'h8, OCC_STS2 = 4'h9, OCC_STS3 = 4'hA, OCC_STS4 = 4'hB,
    OCC_PAL_PULSE = 4'hC, OCC_AUTO2 = 4'hD, OCC_AUTO3 = 4'hE, OCC_AUTO4 = 4'hF
  } occ_mode_t;
  typedef struct packed {
    logic       valid;
    logic [5:0] num;
    logic       err;
    logic       vps_err_bit;
  } occ_byte_t;
endpackage : occ_pkg
`default_nettype wire

//--- core/occ_regs.svh
// Command codes, field positions, reset values and timing counts of the OSD setup commands.
// Assumes an 8-bit command byte with the code byte first and the data byte second.
`ifndef OCC_REGS_SVH
`define OCC_REGS_SVH
`define OCC_CODE_LINE_C    8'hF3
`define OCC_CODE_OSC       8'hF4
`define OCC_CODE_CLK       8'hF5
`define OCC_CODE_SLICER    8'hFA
`define OCC_CODE_ERRPOL    8'hF6
`define OCC_CODE_VPSCHK    8'hF7
`define OCC_CODE_SYNC      8'hFB
`define OCC_RESET_VAL      8'h00
`define OCC_DATA_FLAG_BIT  7
`define OCC_LINE_SEL_LSB   3
`define OCC_LINE_COL_LSB   0
`define OCC_LC_STOP_BIT    5
`define OCC_VCO_STOP_BIT   4
`define OCC_C_SEL_BIT      3
`define OCC_C_VAR_BIT      2
`define OCC_B_SEL_BIT      1
`define OCC_B_VAR_BIT      0
`define OCC_EXT_DOT_LSB    4
`define OCC_JUDGE_LO_BIT   3
`define OCC_JUDGE_HI_BIT   2
`define OCC_H_IN_BIT       1
`define OCC_INT_DOT_BIT    0
`define OCC_THR_ALT_BIT    5
`define OCC_NOISE_LSB      2
`define OCC_SCLK_SEL_LSB   0
`define OCC_ACQ_LSB        4
`define OCC_MODE_LSB       0
`define OCC_VM_START_BIT   6
`define OCC_VM_LEN_BIT     5
`define OCC_RUN_BIT        4
`define OCC_FRAME_BIT      3
`define OCC_BYPASS_BIT     2
`define OCC_UNCHK_WR_BIT   1
`define OCC_UNUSED_OFF_BIT 0
`define OCC_VPS12_BIT      2
`define OCC_ACQ_STEP       8
`define OCC_CLK_NS         8
`define OCC_PAL_S0_NS      677
`define OCC_PAL_S1_NS      903
`define OCC_PAL_S2_NS      450
`define OCC_NTSC_S0_NS     558
`define OCC_NTSC_S1_NS     838
`define OCC_NTSC_S2_NS     1117
`define OCC_NOISE_BASE     4
`define OCC_RUN_LOW        2
`define OCC_RUN_HIGH       4
`endif

//--- dv/occ_control_monitor.sv
// Checker for the OSD setup-command block, bound to its top module.
// Assumes sys_clk and the active-low rst_b are the only clock and reset it needs.
`timescale 1ns/1ps
`default_nettype none
module occ_control_monitor
  import occ_pkg::*;
(
  input wire logic         sys_clk,
  input wire logic         rst_b,
  input wire logic         link_cs_b,
  input wire logic         ext_sync_mode,
  input wire logic         pal_mode,
  input wire logic         line_a_wr,
  input wire logic [3:0]   line_a_row,
  input wire occ_byte_t    byte_req,
  input wire logic [3:0]   third_line_sel,
  input wire logic [2:0]   third_line_color,
  input wire logic         lc_osc_stop,
  input wire logic         vco_stop,
  input wire occ_dot_src_t dot_clk_src,
  input wire logic         h_input_source,
  input wire logic [7:0]   sample_period,
  input wire logic [5:0]   acq_shift,
  input wire occ_mode_t    slicer_mode,
  input wire logic [2:0]   clock_run_count,
  input wire logic         byte_write_valid
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);
  // A frame that has ended long enough ago can no longer be landing in the fields.
  sequence link_idle;
    link_cs_b [*8];
  endsequence
  sequence int_mode;
    !ext_sync_mode [*4];
  endsequence
  run_count_a: assert property (clock_run_count == 3'h2 || clock_run_count == 3'h4)
    else $error("clock run count out of range");
  verdict_pulse_a: assert property (byte_req.valid |=> byte_write_valid)
    else $error("verdict missing after request");
  verdict_quiet_a: assert property (!byte_req.valid |=> !byte_write_valid)
    else $error("verdict without request");
  acq_step_a: assert property (acq_shift[2:0] == 3'h0)
    else $error("phase shift not a multiple of eight");
  dot_code_a: assert property (dot_clk_src != 2'h3)
    else $error("undefined dot clock code");
  int_h_a: assert property (int_mode |-> !h_input_source)
    else $error("H input source set in internal mode");
  int_dot_a: assert property (int_mode |-> dot_clk_src != OCC_DOT_VCO)
    else $error("VCO dot clock in internal mode");
  pal_period_a: assert property (pal_mode [*4] |-> sample_period inside {8'h00, 8'h54, 8'h70, 8'h38})
    else $error("PAL sample period wrong");
  ntsc_period_a: assert property (!pal_mode [*4] |-> sample_period inside {8'h00, 8'h45, 8'h68, 8'h8B})
    else $error("NTSC sample period wrong");
  fields_hold_a: assert property (link_idle |=> $stable({lc_osc_stop, vco_stop, slicer_mode, acq_shift}))
    else $error("fields changed with no frame");
  row_clear_a: assert property ((line_a_wr && line_a_row == third_line_sel && third_line_sel != 4'h0)
    |=> third_line_sel == 4'h0 && third_line_color == 3'h0)
    else $error("third line fields not cleared");
  reset_vals_a: assert property ($rose(rst_b) |-> third_line_sel == 4'h0 && !lc_osc_stop && slicer_mode == OCC_VPS)
    else $error("field not zero after reset");
endmodule : occ_control_monitor
bind occ_control occ_control_monitor u_occ_control_monitor (
  .sys_clk, .rst_b, .link_cs_b, .ext_sync_mode, .pal_mode, .line_a_wr, .line_a_row, .byte_req,
  .third_line_sel, .third_line_color, .lc_osc_stop, .vco_stop, .dot_clk_src, .h_input_source,
  .sample_period, .acq_shift, .slicer_mode, .clock_run_count, .byte_write_valid
);
`default_nettype wire

//--- dv/occ_host_model.sv
// Host model: sends setup bytes over the serial link, MSB first, in one frame.
// Assumes the bench calls send and nothing else drives the link pins.
`timescale 1ns/1ps
`default_nettype none
module occ_host_model (
  output logic link_sclk,
  output logic link_cs_b,
  output logic link_sin
);
  initial begin
    link_sclk = 1'b1;
    link_cs_b = 1'b1;
    link_sin  = 1'b1;
  end
  // The clock idles high between frames and the data line flips once released.
  task automatic send(input logic [23:0] b, input int n);
    link_cs_b = 1'b0;
    #20;
    for (int i = 0; i < n * 8; i++) begin
      link_sclk = 1'b0;
      link_sin  = b[23 - i];
      #6;
      link_sclk = 1'b1;
      #6;
    end
    #40;
    link_cs_b = 1'b1;
    link_sin  = ~link_sin;
  endtask : send
endmodule : occ_host_model
`default_nettype wire

//--- dv/tb.sv
// Testbench of the OSD setup-command block: host frames, verdict requests, line timing.
// Assumes the host model on the serial pins and the checker bound by its own file.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import occ_pkg::*;
  logic sys_clk, rst_b, ext_sync_mode, pal_mode, hsync_extract_in, h_line_start;
  logic lock_in, sync_det_in, line_a_wr, line_b_wr, link_sclk, link_cs_b, link_sin;
  logic line_a_clr, line_b_clr, lc_osc_stop, vco_stop, h_input_source, sync_judge_pin;
  logic sync_present, vmask_start_sel, vmask_length_sel, framing_tolerance_sel;
  logic byte_write_valid, byte_write_ok;
  logic [3:0] disp_row, line_a_row, line_b_row, third_line_sel;
  logic [2:0] third_line_color, clock_run_count;
  logic [1:0] third_rows_mode, second_rows_mode;
  logic [7:0] sample_period, r, d, e, g, o;
  logic [5:0] acq_shift;
  logic [31:0] rs;
  logic [19:0] vt [5];
  occ_byte_t byte_req;
  occ_dot_src_t dot_clk_src;
  occ_mode_t slicer_mode;
  int miscompares, cmp_count, cyc, bclr, aclr;
  occ_host_model u_occ_host_model (.link_sclk, .link_cs_b, .link_sin);
  occ_control u_occ_control (
    .sys_clk, .rst_b, .link_sclk, .link_cs_b, .link_sin, .ext_sync_mode, .pal_mode,
    .hsync_extract_in, .h_line_start, .disp_row, .lock_in, .sync_det_in, .line_a_row,
    .line_a_wr, .line_b_row, .line_b_wr, .byte_req, .third_line_sel, .third_line_color,
    .line_a_clr, .line_b_clr, .lc_osc_stop, .vco_stop, .third_rows_mode, .second_rows_mode,
    .dot_clk_src, .h_input_source, .sync_judge_pin, .sync_present, .sample_period,
    .acq_shift, .slicer_mode, .vmask_start_sel, .vmask_length_sel, .clock_run_count,
    .framing_tolerance_sel, .byte_write_valid, .byte_write_ok
  );
  function automatic logic [7:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs[7:0];
  endfunction : rnd
  function automatic logic [1:0] rvm(input logic s, input logic v);
    return s ? (v ? 2'h2 : 2'h1) : 2'h0;
  endfunction : rvm
  function automatic logic [7:0] per(input logic p, input logic [1:0] s);
    int pns [3] = '{677, 903, 450};
    int nns [3] = '{558, 838, 1117};
    return 8'((p ? pns[s] : nns[s]) / 8);
  endfunction : per
  task automatic print_verdict();
    $display("Comparisons %0d, miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic clks(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : clks
  task automatic cmd(input logic [7:0] c, input logic [7:0] v);
    u_occ_host_model.send({c, v, 8'h00}, 2);
    clks(10);
    #1;
  endtask : cmd
  task automatic lines(input int n);
    repeat (n) begin
      clks(1000);
      h_line_start <= 1'b1;
      clks(1);
      h_line_start <= 1'b0;
    end
    clks(3);
    #1;
  endtask : lines
  task automatic verdict(input logic [5:0] nb, input logic er, input logic vb, input logic ok);
    @(posedge sys_clk);
    byte_req <= '{1'b1, nb, er, vb};
    @(posedge sys_clk);
    byte_req <= '0;
    #1;
    chk({6'h0, byte_write_valid, byte_write_ok}, {6'h0, 1'b1, ok});
  endtask : verdict
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (line_b_clr === 1'b1) bclr++;
    if (line_a_clr === 1'b1) aclr++;
    if (cyc == 40000) begin
      miscompares++;
      print_verdict();
    end
  end
  initial begin
    {rst_b, pal_mode, hsync_extract_in, h_line_start, lock_in, sync_det_in} = 6'h00;
    {line_a_wr, line_b_wr, disp_row, line_a_row, byte_req} = '0;
    ext_sync_mode = 1'b1;
    line_b_row = 4'hC;
    rs = 32'd7947;
    vt = '{20'h0400A, 20'h0204A, 20'h0204C, 20'h00008, 20'h00002};
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    clks(6);
    #1;
    chk({third_line_sel, 1'b0, third_line_color}, 8'h00);
    chk({slicer_mode, lc_osc_stop, vco_stop, acq_shift[4:3]}, 8'h00);
    chk({5'h0, clock_run_count}, 8'h02);
    for (int i = 0; i < 4; i++) begin
      d = rnd() & 8'h3F;
      cmd(8'hF4, d);
      o = {d[5], d[4], 2'h0, rvm(d[3], d[2]), rvm(d[1], d[0])};
      chk({lc_osc_stop, vco_stop, 2'h0, third_rows_mode, second_rows_mode}, o);
    end
    for (int i = 0; i < 3; i++) begin
      r = rnd();
      lock_in <= r[4];
      sync_det_in <= r[5];
      ext_sync_mode <= 1'b1;
      d = {2'h0, 2'(i), r[3:0]};
      cmd(8'hF5, d);
      chk({4'h0, dot_clk_src, h_input_source, 1'b0}, {4'h0, 2'(i), d[1], 1'b0});
      if (d[2]) chk({7'h0, sync_judge_pin}, {7'h0, d[3] ? r[5] : r[4]});
      ext_sync_mode <= 1'b0;
      clks(4);
      #1;
      chk({6'h0, dot_clk_src}, {7'h0, d[0]});
    end
    for (int m = 0; m < 16; m++) begin
      r = rnd();
      cmd(8'hFA, {1'b0, r[2:0], 4'(m)});
      chk({slicer_mode, 1'b0, acq_shift[5:3]}, {4'(m), 1'b0, r[2:0]});
    end
    // A data-position byte with its top bit set starts a new command instead.
    u_occ_host_model.send({8'hF4, 8'hFA, 8'h05}, 3);
    clks(10);
    cmd(8'hFA, 8'h85);
    chk({4'h0, slicer_mode}, 8'h05);
    chk({lc_osc_stop, vco_stop, 2'h0, third_rows_mode, second_rows_mode}, o);
    u_occ_host_model.send({8'hFA, 16'h0000}, 1);
    clks(10);
    // A lone data byte in a fresh frame must not complete the dropped command.
    u_occ_host_model.send({8'h03, 16'h0000}, 1);
    clks(10);
    #1;
    chk({4'h0, slicer_mode}, 8'h05);
    for (int i = 0; i < 4; i++) begin
      d = (rnd() & 8'h68) | (i[0] ? 8'h10 : 8'h00);
      cmd(8'hF6, d);
      e = {d[6], d[5], d[3], 2'h0, d[4] ? 3'h4 : 3'h2};
      g = {vmask_start_sel, vmask_length_sel, framing_tolerance_sel, 2'h0, clock_run_count};
      chk(g, e);
    end
    cmd(8'hFA, 8'h00);
    for (int k = 0; k < 5; k++) begin
      cmd(8'hF6, vt[k][19:12]);
      cmd(8'hF7, vt[k][11:4]);
      verdict(6'hC, vt[k][3], vt[k][2], vt[k][1]);
    end
    cmd(8'hF6, 8'h03);
    verdict(6'h3, 1'b1, 1'b0, 1'b1);
    cmd(8'hF6, 8'h02);
    verdict(6'h3, 1'b1, 1'b0, 1'b0);
    cmd(8'hF3, {1'b0, 4'hC, 3'h7});
    chk({third_line_sel, 1'b0, third_line_color}, 8'hC7);
    chk(8'(bclr), 8'h01);
    @(posedge sys_clk);
    line_a_row <= 4'hC;
    line_a_wr <= 1'b1;
    @(posedge sys_clk);
    line_a_wr <= 1'b0;
    clks(3);
    #1;
    chk({third_line_sel, 1'b0, third_line_color}, 8'h00);
    cmd(8'hF3, {1'b0, 4'hC, 3'h1});
    chk({4'(aclr), 4'(bclr)}, 8'h12);
    for (int p = 0; p < 2; p++)
      for (int s = 0; s < 3; s++) begin
        pal_mode <= p[0];
        cmd(8'hFB, 8'(s));
        chk(sample_period, per(p[0], 2'(s)));
      end
    cmd(8'hF5, 8'h00);
    lines(2);
    chk({6'h0, sync_present, sync_judge_pin}, 8'h03);
    hsync_extract_in <= 1'b1;
    lines(1);
    chk({6'h0, sync_present, sync_judge_pin}, 8'h00);
    hsync_extract_in <= 1'b0;
    cmd(8'hFB, 8'h04);
    lines(2);
    chk({7'h0, sync_present}, 8'h00);
    lines(4);
    chk({7'h0, sync_present}, 8'h01);
    cmd(8'hF4, 8'h3F);
    rst_b <= 1'b0;
    clks(3);
    rst_b <= 1'b1;
    clks(6);
    #1;
    chk({third_line_sel, sync_present, third_line_color}, 8'h00);
    chk({lc_osc_stop, vco_stop, 2'h0, third_rows_mode, second_rows_mode}, 8'h00);
    print_verdict();
  end
endmodule : tb
`default_nettype wire
